// ---- core/rtcsa_pkg.sv ----
package rtcsa_pkg;

    // ==========================================================
    // Seconds alarm compare register layout
    localparam int unsigned SCA_WIDTH     = 8;
    localparam int unsigned SCA_EN_BIT    = 7;
    localparam int unsigned SCA_VAL_MSB   = 6;
    localparam int unsigned SCA_TENS_MSB  = 6;
    localparam int unsigned SCA_TENS_LSB  = 4;
    localparam int unsigned SCA_UNITS_MSB = 3;
    localparam logic [7:0]  SCA_RESET     = 8'h00;

    // ==========================================================
    // Clock trim field
    localparam int unsigned TRIM_WIDTH = 3;
    localparam logic [2:0]  TRIM_RESET = 3'h0;
    localparam logic [2:0]  TRIM_P20   = 3'h1;
    localparam logic [2:0]  TRIM_P40   = 3'h2;
    localparam logic [2:0]  TRIM_P60   = 3'h3;
    localparam logic [2:0]  TRIM_ZERO  = 3'h4;
    localparam logic [2:0]  TRIM_M20   = 3'h5;
    localparam logic [2:0]  TRIM_M40   = 3'h6;
    localparam logic [2:0]  TRIM_M60   = 3'h7;

    // Correction in ppm, two's complement
    localparam logic signed [7:0] PPM_P20  = 8'sh14;
    localparam logic signed [7:0] PPM_P40  = 8'sh28;
    localparam logic signed [7:0] PPM_P60  = 8'sh3c;
    localparam logic signed [7:0] PPM_ZERO = 8'sh00;
    localparam logic signed [7:0] PPM_M20  = -8'sh14;
    localparam logic signed [7:0] PPM_M40  = -8'sh28;
    localparam logic signed [7:0] PPM_M60  = -8'sh3c;

    // ==========================================================
    // Register write port from the device register interface
    typedef struct packed {
        logic       wr_sca;
        logic       wr_trim;
        logic [7:0] wdata;
    } rtcsa_regwr_s;

endpackage

// ---- core/rtcsa_top.sv ----
`timescale 1ns/1ps
module rtcsa_top (
    input  wire logic                             clk_sys,
    input  wire logic                             rst_n,
    input  wire rtcsa_pkg::rtcsa_regwr_s          reg_wr,
    input  wire logic [6:0]                       sec_count,
    input  wire logic                             sec_tick,
    input  wire logic                             other_match,
    input  wire logic                             other_any_en,
    output logic [7:0]                            sca_rdata,
    output logic [rtcsa_pkg::TRIM_WIDTH-1:0]      trim_rdata,
    output logic signed [7:0]                     trim_ppm,
    output logic                                  alarm_match
);
    import rtcsa_pkg::*;

    // ==========================================================
    // Register state
    logic [7:0]            sca_q;
    logic [7:0]            sca_d;
    logic [TRIM_WIDTH-1:0] trim_q;
    logic [TRIM_WIDTH-1:0] trim_d;
    logic signed [7:0]     ppm_q;
    logic signed [7:0]     ppm_d;
    logic signed [7:0]     ppm_dec;
    logic                  match_q;
    logic                  match_d;

    // Alarm field views
    logic                  alarm_seconds_enable;
    logic [6:0]            alarm_seconds_value;
    logic                  tens_eq;
    logic                  units_eq;
    logic                  sec_ok;

    // ==========================================================
    // Trim decoder
    rtcsa_trim_dec u_dec (
        .code (trim_q),
        .ppm  (ppm_dec)
    );

    // Register writes; value stored as written, readback unchanged
    always_comb begin
        sca_d  = sca_q;
        trim_d = trim_q;
        if (reg_wr.wr_sca) begin
            sca_d = reg_wr.wdata;
        end
        if (reg_wr.wr_trim) begin
            trim_d = reg_wr.wdata[TRIM_WIDTH-1:0];
        end
        ppm_d = ppm_dec;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sca_q  <= SCA_RESET;
            trim_q <= TRIM_RESET;
            ppm_q  <= PPM_ZERO;
        end else begin
            sca_q  <= sca_d;
            trim_q <= trim_d;
            ppm_q  <= ppm_d;
        end
    end

    // ==========================================================
    // Seconds compare, digit by digit
    assign alarm_seconds_enable = sca_q[SCA_EN_BIT];
    assign alarm_seconds_value  = sca_q[SCA_VAL_MSB:0];
    assign tens_eq  = (alarm_seconds_value[SCA_TENS_MSB:SCA_TENS_LSB]
                       == sec_count[SCA_TENS_MSB:SCA_TENS_LSB]);
    assign units_eq = (alarm_seconds_value[SCA_UNITS_MSB:0]
                       == sec_count[SCA_UNITS_MSB:0]);
    // Disabled byte counts as matching
    assign sec_ok   = !alarm_seconds_enable || (tens_eq && units_eq);

    // Match is a one-cycle pulse on the seconds update only
    always_comb begin
        match_d = 1'b0;
        if (sec_tick && other_match && sec_ok) begin
            // At least one alarm field must be enabled to fire
            match_d = alarm_seconds_enable || other_any_en;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            match_q <= 1'b0;
        end else begin
            match_q <= match_d;
        end
    end

    // Outputs straight from flops
    assign sca_rdata   = sca_q;
    assign trim_rdata  = trim_q;
    assign trim_ppm    = ppm_q;
    assign alarm_match = match_q;

    // ==========================================================
    // Checks
    sequence s_hit;
        sec_tick && other_match && alarm_seconds_enable && (sec_count == alarm_seconds_value);
    endsequence

    sequence s_arm;
        reg_wr.wr_sca && reg_wr.wdata[SCA_EN_BIT] && !reg_wr.wr_trim;
    endsequence

    // Trim write of the +40 ppm code, then a cycle without a trim write
    sequence s_trim_p40_load;
        reg_wr.wr_trim && (reg_wr.wdata[TRIM_WIDTH-1:0] == TRIM_P40);
    endsequence

    sequence s_trim_quiet;
        !reg_wr.wr_trim;
    endsequence

    // Seconds alarm write that clears the enable bit
    sequence s_disarm;
        reg_wr.wr_sca && !reg_wr.wdata[SCA_EN_BIT];
    endsequence

    AST_TRIM_P20: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (trim_q == TRIM_P20) && !reg_wr.wr_trim |=> ##1 (trim_ppm == PPM_P20))
        else $error("trim 001 did not give +20 ppm");

    AST_TRIM_M60: assert property (@(posedge clk_sys) disable iff (!rst_n)
        reg_wr.wr_trim && (reg_wr.wdata[TRIM_WIDTH-1:0] == TRIM_M60) ##1 !reg_wr.wr_trim
        |=> (trim_ppm == PPM_M60))
        else $error("trim 111 did not give -60 ppm");

    AST_TRIM_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (trim_q == TRIM_ZERO) && $stable(trim_q) |=> (trim_ppm == PPM_ZERO))
        else $error("trim 100 did not give zero");

    AST_DISABLED_IGNORED: assert property (@(posedge clk_sys) disable iff (!rst_n)
        sec_tick && other_match && other_any_en && !alarm_seconds_enable |=> alarm_match)
        else $error("disabled seconds byte blocked the alarm");

    AST_WRITE_STORE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        reg_wr.wr_sca |=> (sca_rdata == $past(reg_wr.wdata)))
        else $error("seconds alarm write not stored");

    AST_HIT_FIRES: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_hit |=> alarm_match)
        else $error("seconds match did not fire alarm");

    AST_ARM_THEN_HIT: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_arm ##1 (!reg_wr.wr_sca && sec_tick && other_match
                   && (sec_count == alarm_seconds_value)) |=> alarm_match)
        else $error("armed seconds alarm missed its match");

    AST_TENS_DIGIT: assert property (@(posedge clk_sys) disable iff (!rst_n)
        alarm_seconds_enable
        && (sec_count[SCA_TENS_MSB:SCA_TENS_LSB] != sca_q[SCA_TENS_MSB:SCA_TENS_LSB]) |=> !alarm_match)
        else $error("tens digit mismatch still fired");

    AST_UNITS_DIGIT: assert property (@(posedge clk_sys) disable iff (!rst_n)
        alarm_seconds_enable
        && (sec_count[SCA_UNITS_MSB:0] != sca_q[SCA_UNITS_MSB:0]) |=> !alarm_match)
        else $error("units digit mismatch still fired");

    AST_ONLY_ON_TICK: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !sec_tick |=> !alarm_match)
        else $error("alarm fired without a seconds update");

    AST_OTHER_QUAL: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !other_match |=> !alarm_match)
        else $error("alarm fired while another field mismatched");

    AST_PULSE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        alarm_match && !sec_tick |=> !alarm_match)
        else $error("alarm pulse held too long");

    // ==========================================================
    // Remaining trim codes, trim load, and register store and hold behaviour
    AST_TRIM_P40: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (trim_q == TRIM_P40) |=> (trim_ppm == PPM_P40))
        else $error("trim 010 did not give +40 ppm");

    AST_TRIM_P60: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (trim_q == TRIM_P60) |=> (trim_ppm == PPM_P60))
        else $error("trim 011 did not give +60 ppm");

    AST_TRIM_M20: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (trim_q == TRIM_M20) |=> (trim_ppm == PPM_M20))
        else $error("trim 101 did not give -20 ppm");

    AST_TRIM_M40: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (trim_q == TRIM_M40) |=> (trim_ppm == PPM_M40))
        else $error("trim 110 did not give -40 ppm");

    AST_TRIM_RESET_CODE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (trim_q == TRIM_RESET) |=> (trim_ppm == PPM_ZERO))
        else $error("reset trim code gave a correction");

    AST_TRIM_P40_LOAD: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_trim_p40_load ##1 s_trim_quiet |=> (trim_ppm == PPM_P40))
        else $error("loaded trim 010 did not reach the ppm output");

    AST_TRIM_STORE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        reg_wr.wr_trim |=> (trim_rdata == $past(reg_wr.wdata[TRIM_WIDTH-1:0])))
        else $error("trim write not stored");

    AST_SCA_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !reg_wr.wr_sca |=> $stable(sca_rdata))
        else $error("seconds alarm register changed without a write");

    AST_TRIM_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !reg_wr.wr_trim |=> $stable(trim_rdata))
        else $error("trim field changed without a write");

    // ==========================================================
    // Further alarm qualification
    AST_NO_FIELD_ENABLED: assert property (@(posedge clk_sys) disable iff (!rst_n)
        sec_tick && !alarm_seconds_enable && !other_any_en |=> !alarm_match)
        else $error("alarm fired with no field enabled");

    AST_SEC_MISMATCH: assert property (@(posedge clk_sys) disable iff (!rst_n)
        alarm_seconds_enable && (sec_count != alarm_seconds_value) |=> !alarm_match)
        else $error("seconds mismatch still fired");

    AST_DISARM_THEN_TICK: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_disarm ##1 (!reg_wr.wr_sca && sec_tick && other_match && other_any_en)
        |=> alarm_match)
        else $error("disarmed seconds byte blocked the alarm");

endmodule

// ---- core/rtcsa_trim_dec.sv ----
`timescale 1ns/1ps
module rtcsa_trim_dec (
    input  wire logic [rtcsa_pkg::TRIM_WIDTH-1:0] code,
    output logic signed [7:0]                     ppm
);
    import rtcsa_pkg::*;

    // ==========================================================
    // Trim code to signed ppm correction; 000 treated as no correction
    always_comb begin
        case (code)
            TRIM_P20: ppm = PPM_P20;
            TRIM_P40: ppm = PPM_P40;
            TRIM_P60: ppm = PPM_P60;
            TRIM_M20: ppm = PPM_M20;
            TRIM_M40: ppm = PPM_M40;
            TRIM_M60: ppm = PPM_M60;
            default:  ppm = PPM_ZERO;
        endcase
    end
endmodule

// ---- tb/test_rtcsa_top.sv ----
`timescale 1ns/1ps
module test_rtcsa_top;
    import rtcsa_pkg::*;
    // ==========================================================
    // Stimulus and observation signals
    logic               clk_sys;
    logic               rst_n;
    rtcsa_regwr_s       reg_wr;
    logic [6:0]         sec_count;
    logic               sec_tick;
    logic               other_match;
    logic               other_any_en;
    logic [7:0]         sca_rdata;
    logic [2:0]         trim_rdata;
    logic signed [7:0]  trim_ppm;
    logic               alarm_match;
    int                 fail_count;
    int                 comparisons;
    int                 ppm_tab [8] = '{0, 20, 40, 60, 0, -20, -40, -60};
    int                 en, val, cnt, om, any, ex, sel;

    rtcsa_top u_rtcsa_top (
        .clk_sys      (clk_sys),
        .rst_n        (rst_n),
        .reg_wr       (reg_wr),
        .sec_count    (sec_count),
        .sec_tick     (sec_tick),
        .other_match  (other_match),
        .other_any_en (other_any_en),
        .sca_rdata    (sca_rdata),
        .trim_rdata   (trim_rdata),
        .trim_ppm     (trim_ppm),
        .alarm_match  (alarm_match)
    );

    // ==========================================================
    // Clock, compare and bus tasks
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // One-cycle write strobe, readback settles after the taking edge
    task automatic wr(input logic s, input logic t, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= '{wr_sca: s, wr_trim: t, wdata: d};
        @(posedge clk_sys);
        reg_wr <= '0;
        #1;
    endtask

    task automatic results();
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Watchdog sized well past the expected run of about 800 cycles
    initial begin
        repeat (6000) @(posedge clk_sys);
        fail_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        results();
    end

    // ==========================================================
    // Main sequence
    initial begin
        rst_n = 1'b0;
        reg_wr = '0;
        sec_count = 7'h00;
        sec_tick = 1'b0;
        other_match = 1'b0;
        other_any_en = 1'b0;
        fail_count = 0;
        comparisons = 0;
        void'($urandom(49017));
        repeat (10) @(posedge clk_sys);
        chk(sca_rdata, SCA_RESET, "sca reset");
        chk({5'h00, trim_rdata}, 8'h00, "trim reset");
        chk({7'h00, alarm_match}, 8'h00, "alarm reset");
        chk(trim_ppm, 8'h00, "ppm reset");
        rst_n <= 1'b1;
        $display("Test reset done");
        // Every trim code, readback then decoded correction
        for (int c = 0; c < 8; c++) begin
            wr(1'b0, 1'b1, 8'($urandom % 32) << 3 | 8'(c));
            chk({5'h00, trim_rdata}, 8'(c), "trim readback");
            @(posedge clk_sys);
            #1;
            chk(trim_ppm, 8'(ppm_tab[c]), "trim ppm");
        end
        $display("Test trim done");
        // Random alarm values, counts and qualifiers against the model
        for (int i = 0; i < 150; i++) begin
            en = $urandom % 2;
            val = ($urandom % 6) * 16 + $urandom % 10;
            wr(1'b1, 1'b0, 8'(en * 128 + val));
            chk(sca_rdata, 8'(en * 128 + val), "sca readback");
            sel = $urandom % 3;
            if (sel == 0) cnt = val;
            else if (sel == 1) cnt = (val & 'h70) | (((val & 'hf) + 1) % 10);
            else cnt = ($urandom % 6) * 16 + $urandom % 10;
            om = ($urandom % 4) != 0;
            any = $urandom % 2;
            ex = om && (!en || (cnt == val)) && (en || any);
            @(posedge clk_sys);
            sec_tick <= 1'b1;
            sec_count <= 7'(cnt);
            other_match <= 1'(om);
            other_any_en <= 1'(any);
            @(posedge clk_sys);
            sec_tick <= 1'b0;
            #1;
            chk({7'h00, alarm_match}, 8'(ex), "alarm on tick");
            @(posedge clk_sys);
            #1;
            chk({7'h00, alarm_match}, 8'h00, "alarm without tick");
        end
        $display("Test alarm done");
        // Write followed at once by a tick, armed then disarmed
        for (int k = 0; k < 2; k++) begin
            @(posedge clk_sys);
            reg_wr <= '{wr_sca: 1'b1, wr_trim: 1'b0, wdata: (k == 0) ? 8'h91 : 8'h11};
            @(posedge clk_sys);
            reg_wr <= '0;
            sec_tick <= 1'b1;
            sec_count <= (k == 0) ? 7'h11 : 7'h25;
            other_match <= 1'b1;
            other_any_en <= 1'b1;
            @(posedge clk_sys);
            sec_tick <= 1'b0;
            #1;
            chk({7'h00, alarm_match}, 8'h01, "alarm after back to back write");
        end
        $display("Test back to back done");
        results();
    end
endmodule
